// [port_pin_mode_config.sv]
// port pin mode configuration: axi4-lite register file for port 2 and 3 pin modes
// assumes a 40 MHz core clock, an external-access pin from outside the clock domain,
// and port 3 output latch bits from core logic on the same clock
`timescale 1ns/1ps
module port_pin_mode_config
   import pin_mode_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // device side
   input wire logic external_access_n_i, // pin, low selects external memory
   input wire logic [7:0] port3_latch_i, // port 3 output latch bits
   output logic [15:0] port2_eff_modes_o, // effective port 2 mode fields
   output logic [15:0] port3_eff_modes_o, // effective port 3 mode fields
   output logic [7:0] port2_pullup_o, // port 2 weak pull-up per pin
   output logic [7:0] port2_drive_high_o, // port 2 may drive high strongly
   output logic [7:0] port2_drive_low_o, // port 2 may drive low
   output logic [7:0] port3_pullup_o,
   output logic [7:0] port3_drive_high_o,
   output logic [7:0] port3_drive_low_o,
   output logic port2_address_bus_o, // port 2 carries external address
   output logic [7:0] port3_alt_enable_o // alternate function active per pin
);
   // ==========================================================
   // external-access pin synchroniser
   logic [2:0] ea_sync_ff, nxt_ea_sync; // three-stage sampler
   logic ea_low_ff, nxt_ea_low; // filtered level, 1 = external access
   // ==========================================================
   // registers
   logic [7:0] port2_lower_pin_modes_ff, nxt_port2_lower_pin_modes;
   logic [7:0] port2_upper_pin_modes_ff, nxt_port2_upper_pin_modes;
   logic [7:0] port3_lower_pin_modes_ff, nxt_port3_lower_pin_modes;
   logic [7:0] port3_upper_pin_modes_ff, nxt_port3_upper_pin_modes;
   logic [7:0] memory_access_control_ff, nxt_memory_access_control;
   // ==========================================================
   // bus state
   logic aw_free_ff, nxt_aw_free; // write address slot empty, drives awready
   logic w_free_ff, nxt_w_free; // write data slot empty, drives wready
   logic ar_free_ff, nxt_ar_free; // no read data pending, drives arready
   logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
   logic [7:0] wdata_ff, nxt_wdata; // low byte lane only
   logic wlane_ff, nxt_wlane; // strobe of byte lane 0
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   // ==========================================================
   // effective pin state
   logic [15:0] p2_eff_ff, nxt_p2_eff, p3_eff_ff, nxt_p3_eff; // effective mode fields
   logic [7:0] p2_pu_ff, p2_dh_ff, p2_dl_ff, p3_pu_ff, p3_dh_ff, p3_dl_ff;
   logic p2_bus_ff, nxt_p2_bus;
   logic [7:0] p3_alt_ff, nxt_p3_alt;
   logic [7:0] p2_pu, p2_pp, p2_od, p3_pu, p3_pp, p3_od; // decoder outputs
   logic ext_mem, p2_ext; // external memory in use
   // does this address hit a register
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = (a == reg_addr(IDX_PORT2_LOWER)) || (a == reg_addr(IDX_PORT2_UPPER))
         || (a == reg_addr(IDX_PORT3_LOWER)) || (a == reg_addr(IDX_PORT3_UPPER))
         || (a == reg_addr(IDX_MEM_ACCESS));
   endfunction
   // ==========================================================
   // synchroniser next state: change counts once stages 2 and 3 agree
   always_comb begin
      nxt_ea_sync = {ea_sync_ff[1:0], ~external_access_n_i};
      nxt_ea_low = (ea_sync_ff[1] == ea_sync_ff[2]) ? ea_sync_ff[2] : ea_low_ff;
   end
   // synchroniser registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ea_sync_ff <= 3'h0;
         ea_low_ff <= 1'b0;
      end else begin
         ea_sync_ff <= nxt_ea_sync;
         ea_low_ff <= nxt_ea_low;
      end
   end

   // ==========================================================
   // axi write and read channels, register updates
   always_comb begin
      nxt_aw_free = aw_free_ff;
      nxt_w_free = w_free_ff;
      nxt_waddr = waddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wlane = wlane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      nxt_port2_lower_pin_modes = port2_lower_pin_modes_ff;
      nxt_port2_upper_pin_modes = port2_upper_pin_modes_ff;
      nxt_port3_lower_pin_modes = port3_lower_pin_modes_ff;
      nxt_port3_upper_pin_modes = port3_upper_pin_modes_ff;
      nxt_memory_access_control = memory_access_control_ff;
      // capture address and data in either order
      if (s_axi_awvalid_i && aw_free_ff) begin
         nxt_aw_free = 1'b0;
         nxt_waddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && w_free_ff) begin
         nxt_w_free = 1'b0;
         nxt_wdata = s_axi_wdata_i[7:0];
         nxt_wlane = s_axi_wstrb_i[0];
      end
      // both held and no response pending: commit whole byte if the lane 0 strobe is set
      if (!aw_free_ff && !w_free_ff && !bvalid_ff) begin
         nxt_aw_free = 1'b1;
         nxt_w_free = 1'b1;
         nxt_bvalid = 1'b1;
         nxt_bresp = addr_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
         if (wlane_ff) begin
            case (waddr_ff)
               reg_addr(IDX_PORT2_LOWER): nxt_port2_lower_pin_modes = wdata_ff;
               reg_addr(IDX_PORT2_UPPER): nxt_port2_upper_pin_modes = wdata_ff;
               reg_addr(IDX_PORT3_LOWER): nxt_port3_lower_pin_modes = wdata_ff;
               reg_addr(IDX_PORT3_UPPER): nxt_port3_upper_pin_modes = wdata_ff;
               reg_addr(IDX_MEM_ACCESS): nxt_memory_access_control = wdata_ff;
               default: ; // unmapped: response only, nothing stored
            endcase
         end
      end
      // response retires when taken
      if (bvalid_ff && s_axi_bready_i) begin
         nxt_bvalid = 1'b0;
      end
      // read: take address while no data pending
      if (rvalid_ff && s_axi_rready_i) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && ar_free_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr_i)
            reg_addr(IDX_PORT2_LOWER): nxt_rdata = {24'h0, port2_lower_pin_modes_ff};
            reg_addr(IDX_PORT2_UPPER): nxt_rdata = {24'h0, port2_upper_pin_modes_ff};
            reg_addr(IDX_PORT3_LOWER): nxt_rdata = {24'h0, port3_lower_pin_modes_ff};
            reg_addr(IDX_PORT3_UPPER): nxt_rdata = {24'h0, port3_upper_pin_modes_ff};
            reg_addr(IDX_MEM_ACCESS): nxt_rdata = {24'h0, memory_access_control_ff};
            default: nxt_rdata = 32'h0; // unmapped reads return zero
         endcase
      end
      // arready is its own flop so the port needs no inverter
      nxt_ar_free = !nxt_rvalid;
   end
   // bus and register flip-flops
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_free_ff <= 1'b1;
         w_free_ff <= 1'b1;
         ar_free_ff <= 1'b1;
         waddr_ff <= '0;
         wdata_ff <= 8'h00;
         wlane_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
         port2_lower_pin_modes_ff <= RESET_PIN_MODES;
         port2_upper_pin_modes_ff <= RESET_PIN_MODES;
         port3_lower_pin_modes_ff <= RESET_PIN_MODES;
         port3_upper_pin_modes_ff <= RESET_PIN_MODES;
         memory_access_control_ff <= RESET_MEM_ACCESS;
      end else begin
         aw_free_ff <= nxt_aw_free;
         w_free_ff <= nxt_w_free;
         ar_free_ff <= nxt_ar_free;
         waddr_ff <= nxt_waddr;
         wdata_ff <= nxt_wdata;
         wlane_ff <= nxt_wlane;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         port2_lower_pin_modes_ff <= nxt_port2_lower_pin_modes;
         port2_upper_pin_modes_ff <= nxt_port2_upper_pin_modes;
         port3_lower_pin_modes_ff <= nxt_port3_lower_pin_modes;
         port3_upper_pin_modes_ff <= nxt_port3_upper_pin_modes;
         memory_access_control_ff <= nxt_memory_access_control;
      end
   end
   // ==========================================================
   // effective modes after external-memory overrides
   always_comb begin
      p2_ext = ea_low_ff || memory_access_control_ff[MAC_PORT2_SEL_BIT];
      ext_mem = p2_ext || memory_access_control_ff[MAC_PORT0_SEL_BIT];
      // field packing: pin n in bits 2n+1..2n
      nxt_p2_eff = {port2_upper_pin_modes_ff, port2_lower_pin_modes_ff};
      nxt_p3_eff = {port3_upper_pin_modes_ff, port3_lower_pin_modes_ff};
      nxt_p2_bus = p2_ext;
      if (p2_ext) begin
         // port 2 becomes address bus, strong drive on every pin
         nxt_p2_eff = {8{MODE_PUSH_PULL}};
      end
      // alternate function with latch at 1; strobe pins also under external memory
      nxt_p3_alt = port3_latch_i;
      if (ext_mem) begin
         // strobe pins ignore their modes and drive active-low strobes
         nxt_p3_eff[2*STROBE_RD_PIN +: 2] = MODE_PUSH_PULL;
         nxt_p3_eff[2*STROBE_WR_PIN +: 2] = MODE_PUSH_PULL;
         nxt_p3_alt[STROBE_RD_PIN] = 1'b1;
         nxt_p3_alt[STROBE_WR_PIN] = 1'b1;
      end
   end
   // decode of the current effective fields
   pin_mode_decode #(.PINS(8)) u_p2_decode (
      .modes_i(nxt_p2_eff),
      .pullup_o(p2_pu),
      .push_pull_o(p2_pp),
      .open_drain_o(p2_od),
      .input_only_o()
   );
   pin_mode_decode #(.PINS(8)) u_p3_decode (
      .modes_i(nxt_p3_eff),
      .pullup_o(p3_pu),
      .push_pull_o(p3_pp),
      .open_drain_o(p3_od),
      .input_only_o()
   );
   // effective pin state registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p2_eff_ff <= 16'h0;
         p3_eff_ff <= 16'h0;
         p2_pu_ff <= 8'hff;
         p2_dh_ff <= 8'h00;
         p2_dl_ff <= 8'hff;
         p3_pu_ff <= 8'hff;
         p3_dh_ff <= 8'h00;
         p3_dl_ff <= 8'hff;
         p2_bus_ff <= 1'b0;
         p3_alt_ff <= 8'h00;
      end else begin
         p2_eff_ff <= nxt_p2_eff;
         p3_eff_ff <= nxt_p3_eff;
         p2_pu_ff <= p2_pu;
         p2_dh_ff <= p2_pp;
         p2_dl_ff <= p2_pu | p2_pp | p2_od;
         p3_pu_ff <= p3_pu;
         p3_dh_ff <= p3_pp;
         p3_dl_ff <= p3_pu | p3_pp | p3_od;
         p2_bus_ff <= nxt_p2_bus;
         p3_alt_ff <= nxt_p3_alt;
      end
   end

   // ==========================================================
   // outputs straight from flip-flops
   assign s_axi_awready_o = aw_free_ff;
   assign s_axi_wready_o = w_free_ff;
   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_arready_o = ar_free_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;
   assign port2_eff_modes_o = p2_eff_ff;
   assign port3_eff_modes_o = p3_eff_ff;
   assign port2_pullup_o = p2_pu_ff;
   assign port2_drive_high_o = p2_dh_ff;
   assign port2_drive_low_o = p2_dl_ff;
   assign port3_pullup_o = p3_pu_ff;
   assign port3_drive_high_o = p3_dh_ff;
   assign port3_drive_low_o = p3_dl_ff;
   assign port2_address_bus_o = p2_bus_ff;
   assign port3_alt_enable_o = p3_alt_ff;
endmodule

// [pin_mode_pkg.sv]
// pin mode package: register indices, field layout, mode encodings, reset values
// assumes registers sit on a 32-bit word bus at byte address = 4 * index
package pin_mode_pkg;
   // ==========================================================
   // register indices and bus geometry
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_PORT2_LOWER = 8'hb1;
   localparam logic [7:0] IDX_PORT2_UPPER = 8'hb2;
   localparam logic [7:0] IDX_PORT3_LOWER = 8'hb3;
   localparam logic [7:0] IDX_PORT3_UPPER = 8'hb4;
   localparam logic [7:0] IDX_MEM_ACCESS = 8'hc0;
   localparam logic [7:0] RESET_PIN_MODES = 8'h00;
   localparam logic [7:0] RESET_MEM_ACCESS = 8'h00;
   // ==========================================================
   // memory access control bit positions
   localparam int MAC_PORT0_SEL_BIT = 1;
   localparam int MAC_PORT2_SEL_BIT = 2;
   // ==========================================================
   // two-bit pin mode encodings, high bit then low bit
   localparam logic [1:0] MODE_QUASI = 2'h0;
   localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
   localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;
   localparam logic [1:0] MODE_INPUT = 2'h3;
   // pins of port 3 that carry the external read and write strobes
   localparam int STROBE_WR_PIN = 6;
   localparam int STROBE_RD_PIN = 7;
   // ==========================================================
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // byte address of a register from its index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'h0, idx, 2'h0};
   endfunction
endpackage

// [pin_mode_decode.sv]
// pin mode decode: turns packed two-bit mode fields into per-pin drive controls
// assumes fields are packed pin 0 in bits 1-0 upward; purely combinational
`timescale 1ns/1ps
module pin_mode_decode
   import pin_mode_pkg::*;
#(
   parameter int PINS = 8
) (
   input wire logic [2*PINS-1:0] modes_i, // packed mode fields
   output logic [PINS-1:0] pullup_o, // weak pull-up enabled
   output logic [PINS-1:0] push_pull_o, // strong drive both ways
   output logic [PINS-1:0] open_drain_o, // drive low only
   output logic [PINS-1:0] input_only_o // output driver off
);
   // ==========================================================
   // per-pin decode of the mode field
   always_comb begin
      pullup_o = '0;
      push_pull_o = '0;
      open_drain_o = '0;
      input_only_o = '0;
      for (int i = 0; i < PINS; i++) begin
         unique case (modes_i[2*i +: 2])
            MODE_QUASI: pullup_o[i] = 1'b1;
            MODE_PUSH_PULL: push_pull_o[i] = 1'b1;
            MODE_OPEN_DRAIN: open_drain_o[i] = 1'b1;
            MODE_INPUT: input_only_o[i] = 1'b1;
         endcase
      end
   end
endmodule

// [port_pin_mode_config_checker.sv]
// checker for port_pin_mode_config: bus handshake timing and pin overrides
// assumes it is bound into port_pin_mode_config and sees only its ports
`timescale 1ns/1ps
module port_pin_mode_config_checker
   import pin_mode_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [7:0] port3_latch_i,
   input wire logic [15:0] port2_eff_modes_o,
   input wire logic [15:0] port3_eff_modes_o,
   input wire logic port2_address_bus_o,
   input wire logic [7:0] port3_alt_enable_o
);
   // ==========================================================
   // helper decode
   logic rd_mapped; // read address hits one of the five registers
   // word-aligned address inside the register set
   always_comb begin
      rd_mapped = (s_axi_araddr_i[1:0] == 2'h0) &&
         (s_axi_araddr_i[ADDR_W-1:2] inside {10'h0b1, 10'h0b2, 10'h0b3, 10'h0b4, 10'h0c0});
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   AST_WRITE_RESP: assert property ((s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o && !s_axi_bvalid_o) |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
      else $error("write response not two cycles after address and data");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped early");
   AST_READ_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data not one cycle after address");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
      $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o)) else $error("read data dropped early");
   AST_R_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o && !rd_mapped |=>
      s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read");
   AST_R_NARROW: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0 &&
      !s_axi_arready_o) else $error("read data wider than a byte or address taken");
   AST_ALT_LATCH: assert property ($past(reset_n_i) |->
      port3_alt_enable_o[5:0] == $past(port3_latch_i[5:0])) else $error("alternate enable");
   AST_PORT2_FORCED: assert property (port2_address_bus_o |-> port2_eff_modes_o == 16'h5555)
      else $error("port2 not push-pull under external memory");
   AST_STROBE_FORCED: assert property (port2_address_bus_o |->
      port3_eff_modes_o[15:12] == 4'h5 && port3_alt_enable_o[7:6] == 2'h3)
      else $error("strobe pins not forced under external memory");
endmodule

bind port_pin_mode_config port_pin_mode_config_checker i_checker (
   .clk_i, .reset_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
   .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
   .port3_latch_i, .port2_eff_modes_o, .port3_eff_modes_o, .port2_address_bus_o,
   .port3_alt_enable_o);

// [port_pin_mode_config_tb.sv]
// testbench for port_pin_mode_config: bus reads and writes with expected values
// assumes the design and its checker are compiled first; one 40 MHz clock
`timescale 1ns/1ps
module port_pin_mode_config_tb
   import pin_mode_pkg::*;
();
   // ==========================================================
   // stimulus and observed signals
   logic clk_i = 1'b0, reset_n_i = 1'b0, external_access_n_i = 1'b1;
   logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
   logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = '0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [7:0] port3_latch_i = 8'h00, port3_alt_enable_o;
   logic [15:0] port2_eff_modes_o, port3_eff_modes_o;
   logic [7:0] port2_pullup_o, port2_drive_high_o, port2_drive_low_o;
   logic [7:0] port3_pullup_o, port3_drive_high_o, port3_drive_low_o;
   logic port2_address_bus_o;
   int fails = 0;
   int n_tests = 0;
   logic [7:0] regs [5] = '{IDX_PORT2_LOWER, IDX_PORT2_UPPER, IDX_PORT3_LOWER,
                            IDX_PORT3_UPPER, IDX_MEM_ACCESS};
   logic [7:0] pat [4] = '{8'he4, 8'h1b, 8'h39, 8'hc6}; // every mode code in each of the four port mode registers
   logic [7:0] bad [2] = '{8'hb0, 8'hb5}; // neighbours of the register set

   port_pin_mode_config i_dut (
      .clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
      .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .external_access_n_i, .port3_latch_i,
      .port2_eff_modes_o, .port3_eff_modes_o, .port2_pullup_o, .port2_drive_high_o,
      .port2_drive_low_o, .port3_pullup_o, .port3_drive_high_o, .port3_drive_low_o,
      .port2_address_bus_o, .port3_alt_enable_o);

   // clock: 25 ns period
   always #12.5 clk_i = ~clk_i;

   // ==========================================================
   // helpers
   function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
      addr_of = ADDR_W'(idx) << 2; // byte address of a register index
   endfunction
   // pins whose two-bit field equals code
   function automatic logic [7:0] pins_in(input logic [15:0] m, input logic [1:0] code);
      for (int i = 0; i < 8; i++) begin
         pins_in[i] = (m[2*i+:2] == code);
      end
   endfunction
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      check_val(32'(got), 32'(exp), "response");
   endtask
   // pin outputs against the expected effective modes
   task automatic check_pins(input logic [15:0] m2, input logic [15:0] m3, input logic [7:0] alt,
                             input logic abus);
      check_val(32'(port2_eff_modes_o), 32'(m2), "port2 modes");
      check_val(32'(port3_eff_modes_o), 32'(m3), "port3 modes");
      check_val(32'(port2_pullup_o), 32'(pins_in(m2, MODE_QUASI)), "port2 pullup");
      check_val(32'(port2_drive_high_o), 32'(pins_in(m2, MODE_PUSH_PULL)), "port2 high");
      check_val(32'(port2_drive_low_o), {24'h0, ~pins_in(m2, MODE_INPUT)}, "port2 low");
      check_val(32'(port3_pullup_o), 32'(pins_in(m3, MODE_QUASI)), "port3 pullup");
      check_val(32'(port3_drive_high_o), 32'(pins_in(m3, MODE_PUSH_PULL)), "port3 high");
      check_val(32'(port3_drive_low_o), {24'h0, ~pins_in(m3, MODE_INPUT)}, "port3 low");
      check_val(32'(port3_alt_enable_o), 32'(alt), "port3 alternate");
      check_val(32'(port2_address_bus_o), 32'(abus), "port2 address bus");
   endtask
   // bus write: address and data offered together, each released when taken
   task automatic wr_chk(input logic [7:0] idx, input logic [7:0] d, input logic strb,
                         input logic [1:0] exp_resp);
      logic aw_wait;
      logic w_wait;
      @(posedge clk_i);
      s_axi_awaddr_i <= addr_of(idx);
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i <= {24'h0, d};
      s_axi_wstrb_i <= {3'h0, strb};
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      aw_wait = 1'b1;
      w_wait = 1'b1;
      while (aw_wait || w_wait) begin
         @(posedge clk_i);
         if (aw_wait && s_axi_awready_o === 1'b1) begin
            aw_wait = 1'b0;
            s_axi_awvalid_i <= 1'b0;
         end
         if (w_wait && s_axi_wready_o === 1'b1) begin
            w_wait = 1'b0;
            s_axi_wvalid_i <= 1'b0;
         end
      end
      while (s_axi_bvalid_o !== 1'b1) @(posedge clk_i);
      check_resp(s_axi_bresp_o, exp_resp);
      s_axi_bready_i <= 1'b0;
   endtask
   // bus read: data and response taken at the edge where rvalid is seen
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] exp_resp);
      @(posedge clk_i);
      s_axi_araddr_i <= addr_of(idx);
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      @(posedge clk_i);
      while (s_axi_arready_o !== 1'b1) @(posedge clk_i);
      s_axi_arvalid_i <= 1'b0;
      @(posedge clk_i);
      while (s_axi_rvalid_o !== 1'b1) @(posedge clk_i);
      check_val(s_axi_rdata_o, exp, "read data");
      check_resp(s_axi_rresp_o, exp_resp);
      s_axi_rready_i <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      check_pins(16'h0, 16'h0, 8'h00, 1'b0);
      foreach (regs[i]) rd_chk(regs[i], 32'h0, RESP_OKAY);
      port3_latch_i <= 8'h3c;
      for (int i = 0; i < 4; i++) begin
         wr_chk(regs[i], pat[i], 1'b1, RESP_OKAY);
         rd_chk(regs[i], 32'(pat[i]), RESP_OKAY);
      end
      repeat (2) @(posedge clk_i);
      check_pins(16'h1be4, 16'hc639, 8'h3c, 1'b0);
      wr_chk(IDX_PORT2_LOWER, 8'hff, 1'b0, RESP_OKAY);
      rd_chk(IDX_PORT2_LOWER, 32'he4, RESP_OKAY);
      foreach (bad[i]) begin
         wr_chk(bad[i], 8'h55, 1'b1, RESP_SLVERR);
         rd_chk(bad[i], 32'h0, RESP_SLVERR);
      end
      // strobe override through the memory control bits, then the pin
      wr_chk(IDX_MEM_ACCESS, 8'h02, 1'b1, RESP_OKAY);
      repeat (2) @(posedge clk_i);
      check_pins(16'h1be4, 16'h5639, 8'hfc, 1'b0);
      rd_chk(IDX_PORT3_UPPER, 32'hc6, RESP_OKAY);
      wr_chk(IDX_MEM_ACCESS, 8'h04, 1'b1, RESP_OKAY);
      repeat (2) @(posedge clk_i);
      check_pins(16'h5555, 16'h5639, 8'hfc, 1'b1);
      rd_chk(IDX_PORT2_UPPER, 32'h1b, RESP_OKAY);
      wr_chk(IDX_MEM_ACCESS, 8'h00, 1'b1, RESP_OKAY);
      external_access_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      check_pins(16'h5555, 16'h5639, 8'hfc, 1'b1);
      external_access_n_i <= 1'b1;
      port3_latch_i <= 8'hc3;
      repeat (10) @(posedge clk_i);
      check_pins(16'h1be4, 16'hc639, 8'hc3, 1'b0);
      // second reset in mid-run returns every register to zero
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      foreach (regs[i]) rd_chk(regs[i], 32'h0, RESP_OKAY);
      check_pins(16'h0, 16'h0, 8'hc3, 1'b0);
      print_verdict();
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      print_verdict();
   end
endmodule
